//--- include/acfr_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  converter clock, filter and reference control block.
  Assumes a 32-bit Wishbone bus with byte addresses.
*/
`ifndef ACFR_REGS_SVH
`define ACFR_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define ACFR_CTRL_ADDR 8'h00
`define ACFR_FILT_ADDR 8'h04
`define ACFR_STAT_ADDR 8'h08
`define ACFR_SETUP_ADDR 8'h10

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define ACFR_CTRL_CLKSEL 0
`define ACFR_CTRL_REFEN 2
`define ACFR_CTRL_REFLVL 3
`define ACFR_CTRL_INTPIN 4
`define ACFR_CTRL_HOLD 5
`define ACFR_CTRL_KEEP 6
`define ACFR_FILT_TYPE 0
`define ACFR_FILT_POST 4
`define ACFR_FILT_DIV 16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACFR_CTRL_RST 7'h00
`define ACFR_DIV_RST 11'h001
`define ACFR_REFSEL_RST 2'h0

// ----------------------------------------------------------------------
// Timing, in main clock periods of 76.8 kHz
// ----------------------------------------------------------------------
`define ACFR_MCLK_HZ 76800
`define ACFR_DEC_BASE 32
`define ACFR_SINC4_MAX 11'h00A
`define ACFR_SINC3_MAX 11'h7FF
`define ACFR_POST1_CNT 20'h00B80
`define ACFR_POST2_CNT 20'h00C80
`define ACFR_POST3_CNT 20'h00F80
`define ACFR_POST4_CNT 20'h01282

`endif

//--- include/acfr_pkg.sv
/*
  Types of the converter clock, filter and reference control block.
  Assumes acfr_regs.svh supplies the numbers.
*/
package acfr_pkg;

  typedef enum logic [1:0] {
    ACFR_CLK_INT,
    ACFR_CLK_INT_OUT,
    ACFR_CLK_EXT,
    ACFR_CLK_EXT_DIV2
  } acfr_clksel_t;

  typedef enum logic [2:0] {
    ACFR_F_SINC4,
    ACFR_F_SINC4_AVG,
    ACFR_F_SINC3,
    ACFR_F_SINC3_REJ,
    ACFR_F_SINC3_AVG,
    ACFR_F_SINC3_POST
  } acfr_filter_t;

  typedef struct packed {
    logic keep_on;
    logic hold;
    logic int_pin;
    logic ref_level;
    logic ref_en;
    acfr_clksel_t clk_sel;
  } acfr_ctrl_t;

  typedef struct packed {
    logic [10:0] filter_rate_divider;
    logic [1:0] post_sel;
    acfr_filter_t ftype;
  } acfr_filt_t;

endpackage

//--- rtl/acfr_ctrl.sv
/*
  Converter clock source, clock pin role, filter output rate and internal
  reference control, with a classic Wishbone register slave.
  Assumes the internal oscillator and the clock pin arrive asynchronously,
  and that the standby request and interrupt come from logic on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acfr_regs.svh"

module acfr_ctrl
  import acfr_pkg::*;
#(
  parameter int NSETUP = 8,
  parameter int AVERAGING_COUNT = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic osc_i,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  input wire logic irq_src_i,
  input wire logic standby_i,
  input wire logic [2:0] setup_idx_i,
  output logic mclk_tick_o,
  output logic mod_tick_o,
  output logic word_tick_o,
  output logic ref_power_o,
  output logic ref_low_o,
  output logic ref_hold_o,
  output logic [1:0] ref_sel_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  acfr_ctrl_t ctrl, next_ctrl;
  acfr_filt_t filt, next_filt;
  logic [1:0] setup_ref [NSETUP];
  logic [1:0] next_setup_ref [NSETUP];
  logic [31:0] next_dat;
  logic next_ack;
  logic [31:0] wmask;
  logic [31:0] wval;

  // Pins cross in through two flops; only the second stage is looked at.
  logic [1:0] osc_s, clk_s;
  logic osc_q, clk_q;
  logic ext_half, next_ext_half;
  logic mod_ph, next_mod_ph;
  logic [19:0] word_cnt, next_word_cnt;
  logic mclk_tick, next_mclk_tick;
  logic next_mod_tick, next_word_tick;
  logic next_pin, next_pin_oe;
  logic [10:0] div_eff;
  logic [19:0] period;
  logic [31:0] filt_word;
  logic next_ref_power, next_ref_low, next_ref_hold;
  logic [1:0] next_ref_sel;

  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign filt_word = {5'h00, filt.filter_rate_divider, 10'h000, filt.post_sel, 1'b0, filt.ftype};

  always_comb begin
    wval = '0;
    next_ctrl = ctrl;
    next_filt = filt;
    for (int i = 0; i < NSETUP; i++) begin
      next_setup_ref[i] = setup_ref[i];
    end
    next_ack = cyc_i & stb_i & ~ack_o;
    next_dat = '0;
    case (adr_i)
      `ACFR_CTRL_ADDR: begin
        wval = (32'(ctrl) & ~wmask) | (dat_i & wmask);
        if (next_ack && we_i) begin
          next_ctrl = acfr_ctrl_t'(wval[6:0]);
        end
        next_dat = 32'(ctrl);
      end
      `ACFR_FILT_ADDR: begin
        wval = (filt_word & ~wmask) | (dat_i & wmask);
        if (next_ack && we_i) begin
          next_filt = acfr_filt_t'({wval[26:16], wval[5:4], wval[2:0]});
        end
        next_dat = filt_word;
      end
      `ACFR_STAT_ADDR: begin
        next_dat = {25'h0000000, ref_low_o, ref_hold_o, ref_power_o, clk_pin_oe_o,
                    div_eff == filt.filter_rate_divider, mod_ph, ext_half};
      end
      default: begin
        if (adr_i >= `ACFR_SETUP_ADDR && adr_i < 8'(`ACFR_SETUP_ADDR + 4 * NSETUP)) begin
          if (next_ack && we_i && sel_i[0]) begin
            next_setup_ref[3'(adr_i[7:2] - 6'h04)] = dat_i[1:0];
          end
          next_dat = {30'h00000000, setup_ref[3'(adr_i[7:2] - 6'h04)]};
        end
      end
    endcase
    if (!next_ack || we_i) begin
      next_dat = '0;
    end
  end

  // ----------------------------------------------------------------------
  // Main clock and modulator clock
  // ----------------------------------------------------------------------
  always_comb begin
    next_mclk_tick = 1'b0;
    next_ext_half = ext_half;
    next_mod_ph = mod_ph;
    next_mod_tick = 1'b0;
    case (ctrl.clk_sel)
      ACFR_CLK_INT, ACFR_CLK_INT_OUT: begin
        next_mclk_tick = osc_s[1] & ~osc_q;
      end
      ACFR_CLK_EXT: begin
        next_mclk_tick = clk_s[1] & ~clk_q;
      end
      default: begin
        if (clk_s[1] & ~clk_q) begin
          next_ext_half = ~ext_half;
          next_mclk_tick = ext_half;
        end
      end
    endcase
    // A source switch can bring two edges into adjacent cycles; dropping the
    // second keeps every main tick a single, separated pulse.
    if (mclk_tick) begin
      next_mclk_tick = 1'b0;
      next_mod_ph = ~mod_ph;
      next_mod_tick = mod_ph;
    end
  end

  // ----------------------------------------------------------------------
  // Output word rate
  // ----------------------------------------------------------------------
  always_comb begin
    // Out-of-range dividers are clamped so the word rate never stops.
    div_eff = filt.filter_rate_divider;
    if (div_eff == 11'h000) begin
      div_eff = 11'h001;
    end
    if ((filt.ftype == ACFR_F_SINC4 || filt.ftype == ACFR_F_SINC4_AVG)
        && div_eff > `ACFR_SINC4_MAX) begin
      div_eff = `ACFR_SINC4_MAX;
    end
    case (filt.ftype)
      ACFR_F_SINC4_AVG: period = 20'(`ACFR_DEC_BASE * div_eff * (4 + AVERAGING_COUNT - 1));
      ACFR_F_SINC3_AVG: period = 20'(`ACFR_DEC_BASE * div_eff * (3 + AVERAGING_COUNT - 1));
      ACFR_F_SINC3_POST: begin
        case (filt.post_sel)
          2'h0: period = `ACFR_POST1_CNT;
          2'h1: period = `ACFR_POST2_CNT;
          2'h2: period = `ACFR_POST3_CNT;
          default: period = `ACFR_POST4_CNT;
        endcase
      end
      ACFR_F_SINC4, ACFR_F_SINC3, ACFR_F_SINC3_REJ: begin
        period = 20'(`ACFR_DEC_BASE * div_eff);
      end
      default: period = 20'(`ACFR_DEC_BASE * div_eff);
    endcase
    next_word_cnt = word_cnt;
    next_word_tick = 1'b0;
    if (mclk_tick) begin
      if (word_cnt >= period - 20'h00001) begin
        next_word_cnt = '0;
        next_word_tick = 1'b1;
      end else begin
        next_word_cnt = word_cnt + 20'h00001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock pin role
  // ----------------------------------------------------------------------
  always_comb begin
    next_pin = 1'b0;
    next_pin_oe = 1'b0;
    if (ctrl.int_pin) begin
      next_pin = irq_src_i;
      next_pin_oe = 1'b1;
    end else if (ctrl.clk_sel == ACFR_CLK_INT_OUT) begin
      next_pin = osc_s[1];
      next_pin_oe = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Reference control
  // ----------------------------------------------------------------------
  // The level only matters while the reference is powered, so it is gated
  // by the same term rather than by the enable bit alone.
  always_comb begin
    next_ref_power = ctrl.ref_en & (~standby_i | ctrl.keep_on);
    next_ref_low = next_ref_power & ctrl.ref_level;
    next_ref_hold = ctrl.ref_en & ctrl.hold & standby_i;
    next_ref_sel = setup_ref[setup_idx_i];
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= acfr_ctrl_t'(`ACFR_CTRL_RST);
      filt <= acfr_filt_t'({`ACFR_DIV_RST, 2'h0, 3'h0});
      for (int i = 0; i < NSETUP; i++) begin
        setup_ref[i] <= `ACFR_REFSEL_RST;
      end
      dat_o <= '0;
      ack_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      filt <= next_filt;
      setup_ref <= next_setup_ref;
      dat_o <= next_dat;
      ack_o <= next_ack;
    end
  end

  // The main tick output is taken from the registered tick so that it stands
  // in the same cycle as the modulator and word ticks derived from it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_s <= '0;
      clk_s <= '0;
      osc_q <= 1'b0;
      clk_q <= 1'b0;
      ext_half <= 1'b0;
      mod_ph <= 1'b0;
      mclk_tick <= 1'b0;
      mclk_tick_o <= 1'b0;
      mod_tick_o <= 1'b0;
    end else begin
      osc_s <= {osc_s[0], osc_i};
      clk_s <= {clk_s[0], clk_pin_i};
      osc_q <= osc_s[1];
      clk_q <= clk_s[1];
      ext_half <= next_ext_half;
      mod_ph <= next_mod_ph;
      mclk_tick <= next_mclk_tick;
      mclk_tick_o <= mclk_tick;
      mod_tick_o <= next_mod_tick;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_cnt <= '0;
      word_tick_o <= 1'b0;
    end else begin
      word_cnt <= next_word_cnt;
      word_tick_o <= next_word_tick;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_pin_o <= 1'b0;
      clk_pin_oe_o <= 1'b0;
    end else begin
      clk_pin_o <= next_pin;
      clk_pin_oe_o <= next_pin_oe;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_power_o <= 1'b0;
      ref_low_o <= 1'b0;
      ref_hold_o <= 1'b0;
      ref_sel_o <= `ACFR_REFSEL_RST;
    end else begin
      ref_power_o <= next_ref_power;
      ref_low_o <= next_ref_low;
      ref_hold_o <= next_ref_hold;
      ref_sel_o <= next_ref_sel;
    end
  end

endmodule

`default_nettype wire

//--- test/acfr_ctrl_assertions.sv
/* Port checker of the converter clock, filter and reference control block.
   Assumes it is bound to every acfr_ctrl instance. */
`timescale 1ns/1ns
`default_nettype none
module acfr_ctrl_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  input wire logic clk_pin_oe_o,
  input wire logic mclk_tick_o,
  input wire logic mod_tick_o,
  input wire logic word_tick_o,
  input wire logic ref_power_o,
  input wire logic ref_low_o,
  input wire logic ref_hold_o
);
  logic odd;
  logic next_odd;
  // Parity of main ticks since reset; the modulator tick lands on every second one.
  always_comb next_odd = odd ^ mclk_tick_o;
  always_ff @(posedge clk_i) odd <= rst_i ? 1'b0 : next_odd;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_mod_in_mclk; mod_tick_o |-> mclk_tick_o; endproperty
  a_mod_in_mclk: assert property (p_mod_in_mclk) else $error("mod tick off main tick");
  property p_mod_parity; mclk_tick_o |-> (mod_tick_o == odd); endproperty
  a_mod_parity: assert property (p_mod_parity) else $error("mod tick not every second");
  property p_tick_single; mclk_tick_o |=> !mclk_tick_o; endproperty
  a_tick_single: assert property (p_tick_single) else $error("main tick too long");
  property p_word_on_mclk; word_tick_o |-> mclk_tick_o; endproperty
  a_word_on_mclk: assert property (p_word_on_mclk) else $error("word tick off main");
  property p_low_needs_en; ref_low_o |-> ref_power_o; endproperty
  a_low_needs_en: assert property (p_low_needs_en) else $error("low level while off");
  property p_hold_standby; ref_hold_o |-> $past(standby_i); endproperty
  a_hold_standby: assert property (p_hold_standby) else $error("hold out of standby");
  property p_ref_off_reset; $past(rst_i) |-> !ref_power_o && !ref_low_o; endproperty
  a_ref_off_reset: assert property (p_ref_off_reset) else $error("reference on at reset");
  property p_pin_off_reset; $past(rst_i) |-> !clk_pin_oe_o; endproperty
  a_pin_off_reset: assert property (p_pin_off_reset) else $error("pin driven at reset");
endmodule
bind acfr_ctrl acfr_ctrl_assertions u_acfr_ctrl_assertions (.clk_i(clk_i), .rst_i(rst_i),
  .standby_i(standby_i), .clk_pin_oe_o(clk_pin_oe_o), .mclk_tick_o(mclk_tick_o),
  .mod_tick_o(mod_tick_o), .word_tick_o(word_tick_o), .ref_power_o(ref_power_o),
  .ref_low_o(ref_low_o), .ref_hold_o(ref_hold_o));
`default_nettype wire

//--- test/acfr_clk_model.sv
/* Square-wave source for the clock pin or the oscillator input.
   Assumes it is enabled only while nobody else drives the line. */
`timescale 1ns/1ns
`default_nettype none
module acfr_clk_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [3:0] half_i,
  output logic wave_o = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // The wave stands low while disabled, as a source that is switched off.
  always @(posedge clk_i) begin
    if (!en_i || cnt == half_i - 4'h1) begin
      cnt <= 4'h0;
      wave_o <= en_i & ~wave_o;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- test/acfr_ctrl_bench.sv
/* Self-checking bench of the clock, filter and reference control block.
   Assumes the checker is bound and the clock models stand at the pins. */
`timescale 1ns/1ns
`default_nettype none
`include "acfr_regs.svh"
module acfr_ctrl_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic irq_src_i = 1'b0, standby_i = 1'b0, osc_i, pin_wave, clk_pin_i, clk_pin_o;
  logic clk_pin_oe_o, ack_o, mclk_tick_o, mod_tick_o, word_tick_o;
  logic ref_power_o, ref_low_o, ref_hold_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [2:0] setup_idx_i = 3'h0;
  logic [1:0] ref_sel_o;
  logic [1:0] refs [8];
  logic [31:0] expq [$];
  int err_total = 0, num_checks = 0, seed = 80315, gcnt = 0, gap = 0, wcnt = 0, per = 0;
  int ftab [6][3] = '{'{2, 2, 64}, '{1, 1, 352}, '{3, 48, 1536}, '{0, 11, 320},
    '{4, 1, 320}, '{5, 0, 2944}};
  int ctab [3][2] = '{'{0, 6}, '{2, 4}, '{3, 8}};
  always #20 clk_i = ~clk_i;
  assign clk_pin_i = clk_pin_oe_o ? clk_pin_o : pin_wave;
  acfr_ctrl u_acfr_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .osc_i(osc_i), .clk_pin_i(clk_pin_i), .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o),
    .irq_src_i(irq_src_i), .standby_i(standby_i), .setup_idx_i(setup_idx_i),
    .mclk_tick_o(mclk_tick_o), .mod_tick_o(mod_tick_o), .word_tick_o(word_tick_o),
    .ref_power_o(ref_power_o), .ref_low_o(ref_low_o), .ref_hold_o(ref_hold_o),
    .ref_sel_o(ref_sel_o));
  acfr_clk_model u_acfr_clk_model (.clk_i(clk_i), .en_i(1'b1), .half_i(4'h3), .wave_o(osc_i));
  acfr_clk_model u_acfr_clk_model_pin (.clk_i(clk_i), .en_i(!clk_pin_oe_o), .half_i(4'h2),
    .wave_o(pin_wave));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // A read hands its expected data in d; the monitor compares it at ack.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    if (!w) expq.push_back(d);
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic words;
    // The first word after a change may be cut short; the second spans a full period.
    repeat (2) begin
      @(posedge clk_i);
      while (word_tick_o !== 1'b1) @(posedge clk_i);
    end
    idle(2);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      chk(dat_o, expq.size() ? expq.pop_front() : 32'hBAD);
    end
    gcnt <= mclk_tick_o ? 1 : gcnt + 1;
    if (mclk_tick_o) gap <= gcnt;
    if (mclk_tick_o) wcnt <= word_tick_o ? 0 : wcnt + 1;
    if (mclk_tick_o && word_tick_o) per <= wcnt + 1;
  end
  initial begin
    #3200000;
    err_total++;
    close_out;
  end
  initial begin
    idle(4);
    rst_i <= 1'b0;
    idle(1);
    bus(1'b0, `ACFR_CTRL_ADDR, 32'h0);
    bus(1'b0, `ACFR_FILT_ADDR, 32'h0001_0000);
    chk(32'(clk_pin_oe_o), 32'h0);
    foreach (ctab[i]) begin
      bus(1'b1, `ACFR_CTRL_ADDR, 32'(ctab[i][0]));
      idle(60);
      chk(32'(gap), 32'(ctab[i][1]));
    end
    bus(1'b1, `ACFR_CTRL_ADDR, 32'h1);
    idle(3);
    chk(32'(clk_pin_oe_o), 32'h1);
    bus(1'b1, `ACFR_CTRL_ADDR, 32'h0);
    foreach (ftab[i]) begin
      bus(1'b1, `ACFR_FILT_ADDR, 32'((ftab[i][1] << 16) | ftab[i][0]));
      words();
      chk(32'(per), 32'(ftab[i][2]));
    end
    bus(1'b1, `ACFR_CTRL_ADDR, 32'h08);
    idle(3);
    chk(32'({ref_power_o, ref_low_o}), 32'h0);
    bus(1'b1, `ACFR_CTRL_ADDR, 32'h0C);
    idle(3);
    chk(32'({ref_power_o, ref_low_o}), 32'h3);
    bus(1'b1, `ACFR_CTRL_ADDR, 32'h6C);
    standby_i <= 1'b1;
    idle(3);
    chk(32'({ref_power_o, ref_hold_o}), 32'h3);
    standby_i <= 1'b0;
    bus(1'b1, `ACFR_CTRL_ADDR, 32'h14);
    irq_src_i <= 1'b1;
    idle(3);
    chk(32'({clk_pin_oe_o, clk_pin_o}), 32'h3);
    irq_src_i <= 1'b0;
    idle(3);
    chk(32'({clk_pin_oe_o, clk_pin_o}), 32'h2);
    for (int i = 0; i < 8; i++) begin
      refs[i] = 2'($random(seed));
      bus(1'b1, 8'(`ACFR_SETUP_ADDR + 4 * i), {30'h0, refs[i]});
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'(`ACFR_SETUP_ADDR + 4 * i), {30'h0, refs[i]});
      setup_idx_i <= 3'(i);
      idle(3);
      chk(32'(ref_sel_o), 32'(refs[i]));
    end
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
    bus(1'b0, 8'hFC, 32'h0);
    idle(4);
    close_out();
  end
endmodule
`default_nettype wire
